/* hw/dual_lin_pkg.sv */
// shared constants and types for the dual lin mode controller
package dual_lin_pkg;

   // clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int MODE_DELAY_NS = 10_000;
   localparam int SETUP_TIME_NS = 8_000;
   localparam int RECOVERY_TIME_NS = 10_000;
   // least times, rounded up to whole cycles
   localparam int MODE_DELAY_CYC =
      (MODE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SETUP_TIME_CYC =
      (SETUP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int RECOVERY_TIME_CYC =
      (RECOVERY_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int COUNT_W = 12;

   // apb register map, byte addresses
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

   // control register fields
   localparam int CTRL_TX_BLOCK_BIT = 0;
   localparam logic CTRL_TX_BLOCK_RST = 1'b0;

   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_SLOPE_BIT = 2;
   localparam int STAT_RELEASED_BIT = 3;
   localparam int STAT_WAKE_LSB = 4;

   // interrupt bits, same layout in status and mask
   localparam int IRQ_N = 4;
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_NORMAL_BIT = 1;
   localparam int IRQ_RELEASE_BIT = 2;
   localparam int IRQ_SLEEP_BIT = 3;
   localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 4'h0;

   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_STANDBY,
      MODE_ENTER,
      MODE_NORMAL
   } mode_t;

   typedef enum logic [1:0] {
      WAKE_NONE,
      WAKE_LOCAL,
      WAKE_BUS1,
      WAKE_BUS2
   } wake_t;

endpackage : dual_lin_pkg

/* hw/dual_lin_mode_control.sv */
// mode, slope and data-path control for a twin lin transceiver
//
// Overview of operation
// - low transmit input drives bus dominant
// - receive output follows bus, low when dominant
// - high transmit releases bus, receive goes high
// - wake-disable input blocks second bus wake
// - three modes, shared by both channels
// - normal offers low slope and normal slope; flash entry is not handled
// - sleep floats inhibit, receive, termination
// - stand-by shows wake source on receive outputs
// - strong pull-down local wake, else weak
// - enable high gives full normal operation
// - output stages recessive during mode change
// - transmit released after both inputs high recovery
// - transmit high at setup selects normal slope
// - transmit low at setup selects low slope
// - mode switches after fixed delay from enable
`timescale 1ns/1ps
module dual_lin_mode_control #(
   parameter int MODE_CYCLES = dual_lin_pkg::MODE_DELAY_CYC,
   parameter int SETUP_CYCLES = dual_lin_pkg::SETUP_TIME_CYC,
   parameter int RECOVERY_CYCLES = dual_lin_pkg::RECOVERY_TIME_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enableIn,
   input wire logic transmit_in_first,
   input wire logic transmit_in_second,
   input wire logic second_bus_wake_disable,
   input wire logic localWake_n,
   input wire logic busLevelFirst,
   input wire logic busLevelSecond,
   output logic busDominantFirst,
   output logic busDominantSecond,
   output logic busTermFirst,
   output logic busTermSecond,
   output logic receive_out_first,
   output logic receive_out_first_oe,
   output logic receive_out_second,
   output logic receive_out_second_oe,
   output logic regulator_inhibit_first,
   output logic regulator_inhibit_first_oe,
   output logic regulator_inhibit_second,
   output logic regulator_inhibit_second_oe,
   output logic txFirstPullStrong,
   output logic txFirstPullWeak,
   output logic slopeLow,
   output logic irq
);

   localparam logic [dual_lin_pkg::COUNT_W-1:0] MODE_LAST =
      dual_lin_pkg::COUNT_W'(MODE_CYCLES - 1);
   localparam logic [dual_lin_pkg::COUNT_W-1:0] SETUP_LAST =
      dual_lin_pkg::COUNT_W'(SETUP_CYCLES - 1);
   localparam logic [dual_lin_pkg::COUNT_W-1:0] REC_LAST =
      dual_lin_pkg::COUNT_W'(RECOVERY_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: en, tx1, tx2, w2o, wake_n, bus1, bus2
   logic [6:0] pinMeta;
   logic [6:0] pinSync;
   logic enSync, tx1Sync, tx2Sync, wakeDisSync, wakeNSync;
   logic bus1Sync, bus2Sync;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinMeta <= 7'h07;
         pinSync <= 7'h07;
      end
      else
      begin
         pinMeta <= {enableIn, transmit_in_first, transmit_in_second,
                     second_bus_wake_disable, localWake_n,
                     busLevelFirst, busLevelSecond};
         pinSync <= pinMeta;
      end
   end

   assign {enSync, tx1Sync, tx2Sync, wakeDisSync, wakeNSync,
           bus1Sync, bus2Sync} = pinSync;

   ////////////////////////////////////////////////////////////////////////
   // mode machine, one for both channels
   dual_lin_pkg::mode_t mode;
   dual_lin_pkg::wake_t wakeSrc;
   logic [dual_lin_pkg::COUNT_W-1:0] modeCnt;
   logic [dual_lin_pkg::COUNT_W-1:0] recCnt;
   logic released;
   logic wakeNPrev, bus1Low, bus2Low;
   logic localWake, bus1Wake, bus2Wake, anyWake;
   logic txBlock;

   // local wake on falling edge, bus wake on dominant-to-recessive
   assign localWake = wakeNPrev && !wakeNSync;
   assign bus1Wake = bus1Low && bus1Sync;
   assign bus2Wake = bus2Low && bus2Sync && !wakeDisSync;
   assign anyWake = localWake || bus1Wake || bus2Wake;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wakeNPrev <= 1'b1;
         bus1Low <= 1'b0;
         bus2Low <= 1'b0;
      end
      else
      begin
         wakeNPrev <= wakeNSync;
         bus1Low <= (mode == dual_lin_pkg::MODE_SLEEP) && !bus1Sync;
         bus2Low <= (mode == dual_lin_pkg::MODE_SLEEP) && !bus2Sync;
      end
   end

   // reset counts as power-up, so stand-by with no wake source
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mode <= dual_lin_pkg::MODE_STANDBY;
         modeCnt <= '0;
      end
      else
      begin
         unique case (mode)
            dual_lin_pkg::MODE_SLEEP, dual_lin_pkg::MODE_STANDBY:
            begin
               modeCnt <= '0;
               if (enSync)
                  mode <= dual_lin_pkg::MODE_ENTER;
               else if (mode == dual_lin_pkg::MODE_SLEEP && anyWake)
                  mode <= dual_lin_pkg::MODE_STANDBY;
            end
            dual_lin_pkg::MODE_ENTER:
            begin
               // still stand-by to the outside until the delay ends
               if (!enSync)
                  mode <= dual_lin_pkg::MODE_SLEEP;
               else if (modeCnt == MODE_LAST)
                  mode <= dual_lin_pkg::MODE_NORMAL;
               modeCnt <= modeCnt + 1'b1;
            end
            dual_lin_pkg::MODE_NORMAL:
            begin
               modeCnt <= '0;
               if (!enSync)
                  mode <= dual_lin_pkg::MODE_SLEEP;
            end
         endcase
      end
   end

   // only the first wake is remembered; cleared on reaching normal
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wakeSrc <= dual_lin_pkg::WAKE_NONE;
      else if (mode == dual_lin_pkg::MODE_NORMAL)
         wakeSrc <= dual_lin_pkg::WAKE_NONE;
      else if (mode == dual_lin_pkg::MODE_SLEEP && !enSync &&
               wakeSrc == dual_lin_pkg::WAKE_NONE)
      begin
         if (localWake)
            wakeSrc <= dual_lin_pkg::WAKE_LOCAL;
         else if (bus1Wake)
            wakeSrc <= dual_lin_pkg::WAKE_BUS1;
         else if (bus2Wake)
            wakeSrc <= dual_lin_pkg::WAKE_BUS2;
      end
   end

   // slope latched once at the setup point; flash entry is not handled
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         slopeLow <= 1'b0;
      else if (mode == dual_lin_pkg::MODE_ENTER && modeCnt == SETUP_LAST)
         slopeLow <= !tx1Sync;
   end

   // transmit stays blocked until both inputs stay high long enough
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         released <= 1'b0;
         recCnt <= '0;
      end
      else if (mode != dual_lin_pkg::MODE_NORMAL || !enSync)
      begin
         released <= 1'b0;
         recCnt <= '0;
      end
      else if (!released)
      begin
         if (!(tx1Sync && tx2Sync))
            recCnt <= '0;
         else if (recCnt == REC_LAST)
            released <= 1'b1;
         else
            recCnt <= recCnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus drivers and pin outputs
   logic isNormal, isSleep, isStandby;

   assign isNormal = (mode == dual_lin_pkg::MODE_NORMAL);
   assign isSleep = (mode == dual_lin_pkg::MODE_SLEEP);
   // enter looks like stand-by from outside
   assign isStandby = !isNormal && !isSleep;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busDominantFirst <= 1'b0;
         busDominantSecond <= 1'b0;
      end
      else
      begin
         // recessive whenever not released, incl. mode change
         busDominantFirst <= isNormal && enSync && released &&
                             !txBlock && !tx1Sync;
         busDominantSecond <= isNormal && enSync && released &&
                              !txBlock && !tx2Sync;
      end
   end

   always_comb
   begin
      receive_out_first_oe = !isSleep;
      receive_out_second_oe = !isSleep;
      if (isNormal)
      begin
         receive_out_first = bus1Sync;
         receive_out_second = bus2Sync;
      end
      else
      begin
         receive_out_first = (wakeSrc == dual_lin_pkg::WAKE_NONE);
         receive_out_second = (wakeSrc != dual_lin_pkg::WAKE_BUS2);
      end
   end

   assign regulator_inhibit_first = 1'b1;
   assign regulator_inhibit_second = 1'b1;
   assign regulator_inhibit_first_oe = !isSleep;
   assign regulator_inhibit_second_oe = !isSleep;
   assign busTermFirst = !isSleep;
   assign busTermSecond = !isSleep;
   assign txFirstPullStrong = isStandby &&
                              (wakeSrc == dual_lin_pkg::WAKE_LOCAL);
   assign txFirstPullWeak = !txFirstPullStrong;

   ////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait, read data captured in setup phase
   logic [dual_lin_pkg::IRQ_N-1:0] irqStatus, irqMask, irqEvent;
   logic wrAccess;
   logic releasedPrev;
   dual_lin_pkg::mode_t modePrev;

   function automatic logic addrKnown(input logic [7:0] a);
      addrKnown = (a == dual_lin_pkg::CTRL_OFS) ||
                  (a == dual_lin_pkg::STATUS_OFS) ||
                  (a == dual_lin_pkg::IRQ_STATUS_OFS) ||
                  (a == dual_lin_pkg::IRQ_MASK_OFS);
   endfunction : addrKnown

   assign wrAccess = psel && penable && pwrite;
   assign pready = 1'b1;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= !addrKnown(paddr);
         prdata <= 32'h0000_0000;
         unique case (paddr)
            dual_lin_pkg::CTRL_OFS:
               prdata[dual_lin_pkg::CTRL_TX_BLOCK_BIT] <= txBlock;
            dual_lin_pkg::STATUS_OFS:
            begin
               prdata[dual_lin_pkg::STAT_MODE_LSB +: 2] <= mode;
               prdata[dual_lin_pkg::STAT_SLOPE_BIT] <= slopeLow;
               prdata[dual_lin_pkg::STAT_RELEASED_BIT] <= released;
               prdata[dual_lin_pkg::STAT_WAKE_LSB +: 2] <= wakeSrc;
            end
            dual_lin_pkg::IRQ_STATUS_OFS:
               prdata[dual_lin_pkg::IRQ_N-1:0] <= irqStatus;
            dual_lin_pkg::IRQ_MASK_OFS:
               prdata[dual_lin_pkg::IRQ_N-1:0] <= irqMask;
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         txBlock <= dual_lin_pkg::CTRL_TX_BLOCK_RST;
         irqMask <= dual_lin_pkg::IRQ_MASK_RST;
      end
      else if (wrAccess && paddr == dual_lin_pkg::CTRL_OFS)
         txBlock <= pwdata[dual_lin_pkg::CTRL_TX_BLOCK_BIT];
      else if (wrAccess && paddr == dual_lin_pkg::IRQ_MASK_OFS)
         irqMask <= pwdata[dual_lin_pkg::IRQ_N-1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt events; a new event beats a same-cycle clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         modePrev <= dual_lin_pkg::MODE_STANDBY;
         releasedPrev <= 1'b0;
      end
      else
      begin
         modePrev <= mode;
         releasedPrev <= released;
      end
   end

   always_comb
   begin
      irqEvent = '0;
      irqEvent[dual_lin_pkg::IRQ_WAKE_BIT] =
         (modePrev == dual_lin_pkg::MODE_SLEEP) && isStandby &&
         (mode == dual_lin_pkg::MODE_STANDBY);
      irqEvent[dual_lin_pkg::IRQ_NORMAL_BIT] =
         isNormal && (modePrev != dual_lin_pkg::MODE_NORMAL);
      irqEvent[dual_lin_pkg::IRQ_RELEASE_BIT] = released && !releasedPrev;
      irqEvent[dual_lin_pkg::IRQ_SLEEP_BIT] =
         isSleep && (modePrev != dual_lin_pkg::MODE_SLEEP);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irqStatus <= '0;
      else if (wrAccess && paddr == dual_lin_pkg::IRQ_STATUS_OFS)
         irqStatus <= (irqStatus & ~pwdata[dual_lin_pkg::IRQ_N-1:0]) |
                      irqEvent;
      else
         irqStatus <= irqStatus | irqEvent;
   end

   assign irq = |(irqStatus & irqMask);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   tx_dominant_a: assert property (
      (isNormal && enSync && released && !txBlock && !tx1Sync)
      |=> busDominantFirst)
      else $error("bus one not dominant for low transmit");

   rx_follow_a: assert property (
      isNormal |-> receive_out_second == bus2Sync)
      else $error("receive two does not follow bus two");

   tx_release_a: assert property (
      $rose(tx1Sync) |=> !busDominantFirst)
      else $error("bus one not released after high transmit");

   wake_block_a: assert property (
      (isSleep && wakeDisSync && !localWake && !bus1Wake)
      |=> wakeSrc != dual_lin_pkg::WAKE_BUS2 || $past(wakeSrc) ==
          dual_lin_pkg::WAKE_BUS2)
      else $error("bus two wake taken while disabled");

   sleep_float_a: assert property (
      isSleep |-> !receive_out_first_oe && !regulator_inhibit_second_oe &&
                  !busTermFirst && !busDominantSecond)
      else $error("sleep outputs not floating");

   standby_rx_a: assert property (
      (isStandby && wakeSrc == dual_lin_pkg::WAKE_BUS2)
      |-> !receive_out_first && !receive_out_second)
      else $error("bus two wake not shown on receive outputs");

   pull_strong_a: assert property (
      (isStandby && wakeSrc == dual_lin_pkg::WAKE_LOCAL)
      |-> txFirstPullStrong && !txFirstPullWeak)
      else $error("no strong pull-down after local wake");

   change_quiet_a: assert property (
      (mode == dual_lin_pkg::MODE_ENTER) |=> !busDominantFirst &&
                                           !busDominantSecond)
      else $error("bus driven during mode change");

   release_wait_a: assert property (
      $rose(released) |-> $past(recCnt) == REC_LAST &&
                          $past(tx1Sync) && $past(tx2Sync))
      else $error("transmit released before recovery");

   slope_pick_a: assert property (
      (mode == dual_lin_pkg::MODE_ENTER && modeCnt == SETUP_LAST)
      |=> slopeLow == !$past(tx1Sync))
      else $error("slope not taken from first transmit");

   mode_delay_a: assert property (
      $rose(isNormal) |-> $past(modeCnt) == MODE_LAST &&
                          $past(mode) == dual_lin_pkg::MODE_ENTER)
      else $error("normal entered off the mode delay");

   enter_low_c: cover property (
      $rose(isNormal) && slopeLow);
   enter_fast_c: cover property (
      $rose(isNormal) && !slopeLow);
   release_c: cover property ($rose(released));
   wake_bus2_c: cover property (
      $rose(wakeSrc == dual_lin_pkg::WAKE_BUS2));

endmodule : dual_lin_mode_control

/* tb/lin_bus_model.sv */
// two single-wire lin buses with pull-ups, shared with remote nodes
`timescale 1ns/1ps
module lin_bus_model (
   input wire logic busDominantFirst,
   input wire logic busDominantSecond,
   input wire logic [1:0] remoteDominant,
   output logic busLevelFirst,
   output logic busLevelSecond
);
   // wired-and: any node pulling low wins, else the pull-up gives recessive
   assign busLevelFirst = !(busDominantFirst || remoteDominant[0]);
   assign busLevelSecond = !(busDominantSecond || remoteDominant[1]);
endmodule : lin_bus_model

/* tb/testbench.sv */
// self-checking bench for the dual lin mode controller
`timescale 1ns/1ps
module testbench;
   typedef struct {
      string name;
      int sel;
      logic [31:0] mask;
      logic [31:0] exp;
   } note_t;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, lastErr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, lastRead;
   logic enableIn, transmit_in_first, transmit_in_second, localWake_n;
   logic second_bus_wake_disable, busLevelFirst, busLevelSecond;
   logic busDominantFirst, busDominantSecond, busTermFirst, busTermSecond;
   logic receive_out_first, receive_out_first_oe, txFirstPullStrong;
   logic receive_out_second, receive_out_second_oe, txFirstPullWeak;
   logic regulator_inhibit_first, regulator_inhibit_first_oe, slopeLow;
   logic regulator_inhibit_second, regulator_inhibit_second_oe;
   logic [1:0] remoteDominant;
   logic [13:0] pins;
   logic [31:0] r;
   int failures, compares;
   integer seed;
   note_t notes[$];
   event chk;

   dual_lin_mode_control #(.MODE_CYCLES(8), .SETUP_CYCLES(4),
      .RECOVERY_CYCLES(5)) dut (.clk, .rst, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .enableIn,
      .transmit_in_first, .transmit_in_second, .second_bus_wake_disable,
      .localWake_n, .busLevelFirst, .busLevelSecond, .busDominantFirst,
      .busDominantSecond, .busTermFirst, .busTermSecond, .receive_out_first,
      .receive_out_first_oe, .receive_out_second, .receive_out_second_oe,
      .regulator_inhibit_first, .regulator_inhibit_first_oe,
      .regulator_inhibit_second, .regulator_inhibit_second_oe,
      .txFirstPullStrong, .txFirstPullWeak, .slopeLow, .irq);
   lin_bus_model bus (.busDominantFirst, .busDominantSecond,
      .remoteDominant, .busLevelFirst, .busLevelSecond);

   assign pins = {irq, slopeLow, txFirstPullWeak, txFirstPullStrong,
      busTermSecond, busTermFirst, regulator_inhibit_second_oe,
      regulator_inhibit_first_oe, receive_out_second_oe,
      receive_out_first_oe, receive_out_second, receive_out_first,
      busDominantSecond, busDominantFirst};

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task check(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // watcher: drains the notes against what the block shows right now
   always @(chk)
   begin : watch
      note_t n;
      logic [31:0] seen;
      while (notes.size() > 0)
      begin
         n = notes.pop_front();
         seen = n.sel == 0 ? lastRead : n.sel == 1 ? {31'h0, lastErr} :
            {18'h0, pins};
         check(n.name, seen & n.mask, n.exp);
      end
   end

   task note(string name, int sel, logic [31:0] mask, logic [31:0] exp);
      notes.push_back('{name, sel, mask, exp});
      ->chk;
   endtask : note

   task pinsAre(string name, logic [13:0] m, logic [13:0] v);
      note(name, 2, {18'h0, m}, {18'h0, v});
   endtask : pinsAre

   task cycles(int n);
      repeat (n) @(posedge clk);
   endtask : cycles

   // one apb transfer; entered and left just after a rising edge
   task apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         complete_run();
      end
      lastRead = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task rd(string name, logic [7:0] a, logic [31:0] m, logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      note(name, 0, m, e);
   endtask : rd

   task waitMode(logic [1:0] m);
      int i;
      i = 0;
      do
      begin
         apb(1'b0, dual_lin_pkg::STATUS_OFS, 32'h0000_0000);
         i++;
      end while (lastRead[1:0] !== m && i < 30);
      if (lastRead[1:0] !== m)
      begin
         failures++;
         complete_run();
      end
   endtask : waitMode

   task remotePulse(int ch);
      remoteDominant[ch] <= 1'b1;
      cycles(4);
      remoteDominant[ch] <= 1'b0;
      cycles(10);
   endtask : remotePulse

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 32'hb6b6;
      rst = 1'b1;
      {psel, penable, pwrite, enableIn, second_bus_wake_disable} = 5'h0;
      {transmit_in_first, transmit_in_second, localWake_n} = 3'h7;
      {paddr, pwdata, remoteDominant} = 42'h0;
      cycles(20);
      rst <= 1'b0;
      @(posedge clk);
      pinsAre("reset pins", 14'h3fff, 14'h0bfc);
      rd("status", dual_lin_pkg::STATUS_OFS, 32'hffff_ffff, 32'h1);
      rd("mask", dual_lin_pkg::IRQ_MASK_OFS, 32'h0000_000f, 32'h0);
      apb(1'b0, 8'h10, 32'h0000_0000);
      note("unmapped", 1, 32'h0000_0001, 32'h0000_0001);
      $display("test reset done");
      // tx1 high and untouched until the switch: normal slope
      enableIn <= 1'b1;
      transmit_in_second <= 1'b0;
      cycles(5);
      rd("entering", dual_lin_pkg::STATUS_OFS, 32'h3, 32'h2);
      pinsAre("quiet change", 14'h0003, 14'h0000);
      cycles(10);
      pinsAre("held tx2", 14'h0003, 14'h0000);
      rd("unreleased", dual_lin_pkg::STATUS_OFS, 32'h8, 32'h0);
      transmit_in_second <= 1'b1;
      cycles(12);
      rd("normal", dual_lin_pkg::STATUS_OFS, 32'hff, 32'hb);
      pinsAre("normal pins", 14'h13f0, 14'h03f0);
      rd("irq", dual_lin_pkg::IRQ_STATUS_OFS, 32'hf, 32'h6);
      apb(1'b1, dual_lin_pkg::IRQ_MASK_OFS, 32'h0000_0002);
      cycles(2);
      pinsAre("irq on", 14'h2000, 14'h2000);
      apb(1'b1, dual_lin_pkg::IRQ_STATUS_OFS, 32'h0000_0002);
      cycles(2);
      pinsAre("irq off", 14'h2000, 14'h0000);
      rd("irq w1c", dual_lin_pkg::IRQ_STATUS_OFS, 32'hf, 32'h4);
      apb(1'b1, dual_lin_pkg::IRQ_MASK_OFS, 32'h0000_0008);
      $display("test normal entry done");
      repeat (8)
      begin
         r = $random(seed);
         transmit_in_first <= r[0];
         transmit_in_second <= r[1];
         cycles(10);
         pinsAre("data", 14'h000f, {10'h0, r[1], r[0], ~r[1], ~r[0]});
      end
      {transmit_in_first, transmit_in_second} <= 2'b11;
      remoteDominant <= 2'b01;
      cycles(10);
      pinsAre("remote", 14'h000f, 14'h0008);
      // control block bit must hold both buses recessive
      apb(1'b1, dual_lin_pkg::CTRL_OFS, 32'h0000_0001);
      {transmit_in_first, transmit_in_second} <= 2'b00;
      cycles(10);
      pinsAre("blocked", 14'h0003, 14'h0000);
      rd("ctrl", dual_lin_pkg::CTRL_OFS, 32'h1, 32'h1);
      // back to idle high before unblocking, else a false bus wake
      {transmit_in_first, transmit_in_second} <= 2'b11;
      apb(1'b1, dual_lin_pkg::CTRL_OFS, 32'h0000_0000);
      cycles(4);
      $display("test data path done");
      // host lets go of the pins in sleep; pull-downs bring them low
      enableIn <= 1'b0;
      remoteDominant <= 2'b00;
      {transmit_in_first, transmit_in_second} <= 2'b00;
      cycles(10);
      pinsAre("sleep pins", 14'h23f3, 14'h2000);
      rd("sleep", dual_lin_pkg::STATUS_OFS, 32'h3, 32'h0);
      apb(1'b1, dual_lin_pkg::IRQ_STATUS_OFS, 32'h0000_0008);
      cycles(2);
      pinsAre("irq clear", 14'h2000, 14'h0000);
      second_bus_wake_disable <= 1'b1;
      cycles(4);
      remotePulse(1);
      rd("no wake", dual_lin_pkg::STATUS_OFS, 32'h3, 32'h0);
      second_bus_wake_disable <= 1'b0;
      cycles(4);
      remotePulse(1);
      rd("bus2 wake", dual_lin_pkg::STATUS_OFS, 32'h33, 32'h31);
      pinsAre("bus2 pins", 14'h0ffc, 14'h0bf0);
      remotePulse(0);
      rd("first wins", dual_lin_pkg::STATUS_OFS, 32'h30, 32'h30);
      rd("wake irq", dual_lin_pkg::IRQ_STATUS_OFS, 32'h1, 32'h1);
      $display("test bus wake done");
      // tx1 held low through the switch: low slope
      transmit_in_second <= 1'b1;
      enableIn <= 1'b1;
      waitMode(2'h3);
      rd("low slope", dual_lin_pkg::STATUS_OFS, 32'h3c, 32'h4);
      pinsAre("low pins", 14'h1003, 14'h1000);
      $display("test low slope done");
      enableIn <= 1'b0;
      transmit_in_second <= 1'b0;
      cycles(10);
      localWake_n <= 1'b0;
      cycles(4);
      localWake_n <= 1'b1;
      cycles(10);
      rd("local wake", dual_lin_pkg::STATUS_OFS, 32'h33, 32'h11);
      pinsAre("local pins", 14'h0ffc, 14'h07f8);
      $display("test local wake done");
      complete_run();
   end
endmodule : testbench
